// ==== hw/gtc_params.svh ====
// Purpose: Constants for the gated 16-bit timer/counter
// Assumes: Included by the timer design file
// Notes:   Offsets are AHB byte addresses
`ifndef GTC_PARAMS_SVH
`define GTC_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GTC_OFS_CNT_LO     8'h00
`define GTC_OFS_CNT_HI     8'h04
`define GTC_OFS_TCTRL      8'h08
`define GTC_OFS_GCTRL      8'h0C
`define GTC_OFS_STATUS     8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GTC_TC_ON          0
`define GTC_TC_SYNC_DIS    2
`define GTC_TC_PS_LO       4
`define GTC_TC_PS_HI       5
`define GTC_TC_CS_LO       6
`define GTC_TC_CS_HI       7
`define GTC_GC_GSS         0
`define GTC_GC_GVAL        2
`define GTC_GC_TM          5
`define GTC_GC_POL         6
`define GTC_GC_GE          7
`define GTC_ST_OVF         0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define GTC_RST_BYTE       8'h00
`define GTC_RST_CNT        16'h0000
`define GTC_CNT_MAX        16'hFFFF
`define GTC_CNT_ONE        16'h0001
`define GTC_WRAP_FROM      8'hFF
`define GTC_WRAP_TO        8'h00
`define GTC_INSTR_LAST     2'h3
`define GTC_INSTR_ONE      2'h1
`define GTC_PRE_ONE        3'h1
`define GTC_PRE_ZERO       3'h0

`endif

// ==== hw/gtc_pkg.sv ====
// Purpose: Types for the gated 16-bit timer/counter
// Assumes: Nothing
// Notes:   Field encodings as seen by software
`default_nettype none

package gtc_pkg;

	// ----------------------------------------
	// Count clock source
	// ----------------------------------------
	typedef enum logic [1:0] {
		GTC_CS_INSTR = 2'h0,
		GTC_CS_SYS   = 2'h1,
		GTC_CS_PIN   = 2'h2,
		GTC_CS_LFOSC = 2'h3
	} gtc_clk_src_t;

	// ----------------------------------------
	// Prescale select
	// ----------------------------------------
	typedef enum logic [1:0] {
		GTC_PS_DIV1 = 2'h0,
		GTC_PS_DIV2 = 2'h1,
		GTC_PS_DIV4 = 2'h2,
		GTC_PS_DIV8 = 2'h3
	} gtc_prescale_t;

endpackage

`default_nettype wire

// ==== hw/gtc_timer.sv ====
// Purpose: Gated 16-bit up timer/counter with 2-bit prescaler, AHB-Lite slave
// Assumes: One clock; pins are asynchronous; companion count on clk_sys_i
// Notes:   Asynchronous count mode is emulated on the system clock
`include "gtc_params.svh"
`default_nettype none

module gtc_timer (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_b_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        external_count_clock_pin_i,
	input  wire logic        gate_pin_i,
	input  wire logic        low_freq_internal_osc_i,
	input  wire logic [7:0]  companion_count_i,
	input  wire logic        sleep_i,
	output logic             overflow_flag_o,
	output logic             wake_o
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0]  haddr_r;
	logic        wr_pend_r;
	logic [31:0] hrdata_r;
	logic        acc_ok;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic        on_r;
	logic        sync_dis_r;
	logic        ge_r;
	logic        pol_r;
	logic        tm_r;
	logic        gss_r;
	logic        ovf_r;
	logic        wake_r;
	gtc_pkg::gtc_clk_src_t  cs_r;
	gtc_pkg::gtc_prescale_t ps_r;
	logic [2:0]  pin_s_r;
	logic [2:0]  gpin_s_r;
	logic [2:0]  lfo_s_r;
	logic        pin_lvl_r;
	logic        pin_dly_r;
	logic        gpin_lvl_r;
	logic        lfo_lvl_r;
	logic        lfo_dly_r;
	logic        pin_prev_r;
	logic        pin_use;
	logic        arm_r;
	logic [7:0]  comp_prev_r;
	logic        wrap_pulse;
	logic        gsrc;
	logic        gsrc_prev_r;
	logic        tff_r;
	logic        gate_lvl;
	logic        gate_ok;
	logic [1:0]  instr_div_r;
	logic [2:0]  pre_r;
	logic        src_tick;
	logic        pre_tick;
	logic        run_ok;
	logic        count_en;
	logic        inc;
	logic        wr_lo;
	logic        wr_hi;
	logic        wr_cnt;
	logic        wr_tc;
	logic        wr_gc;
	logic        wr_st;

	// Mask of prescale bits that must all be set for one output tick
	function automatic logic [2:0] pre_mask(input gtc_pkg::gtc_prescale_t ps);
		case (ps)
			gtc_pkg::GTC_PS_DIV1: pre_mask = 3'h0;
			gtc_pkg::GTC_PS_DIV2: pre_mask = 3'h1;
			gtc_pkg::GTC_PS_DIV4: pre_mask = 3'h3;
			gtc_pkg::GTC_PS_DIV8: pre_mask = 3'h7;
			default:              pre_mask = 3'h0;
		endcase
	endfunction

	// Agreed level of a three-stage synchroniser
	function automatic logic sync_lvl(input logic [2:0] s, input logic old);
		sync_lvl = (s[1] == s[2]) ? s[2] : old;
	endfunction

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign acc_ok      = hsel_i & htrans_i[1] & hready_i;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = hrdata_r;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			haddr_r   <= 8'h00;
			wr_pend_r <= 1'b0;
		end else begin
			wr_pend_r <= acc_ok & hwrite_i;
			if (acc_ok) begin
				haddr_r <= haddr_i[7:0];
			end
		end
	end

	assign wr_lo  = wr_pend_r && (haddr_r == `GTC_OFS_CNT_LO);
	assign wr_hi  = wr_pend_r && (haddr_r == `GTC_OFS_CNT_HI);
	assign wr_tc  = wr_pend_r && (haddr_r == `GTC_OFS_TCTRL);
	assign wr_gc  = wr_pend_r && (haddr_r == `GTC_OFS_GCTRL);
	assign wr_st  = wr_pend_r && (haddr_r == `GTC_OFS_STATUS);
	assign wr_cnt = wr_lo | wr_hi;

	// Read data captured in the address phase; unmapped reads give zero
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			hrdata_r <= 32'h0000_0000;
		end else if (acc_ok && !hwrite_i) begin
			hrdata_r <= 32'h0000_0000;
			case (haddr_i[7:0])
				`GTC_OFS_CNT_LO: hrdata_r[7:0] <= count_r[7:0];
				`GTC_OFS_CNT_HI: hrdata_r[7:0] <= count_r[15:8];
				`GTC_OFS_TCTRL: begin
					hrdata_r[`GTC_TC_CS_HI:`GTC_TC_CS_LO] <= cs_r;
					hrdata_r[`GTC_TC_PS_HI:`GTC_TC_PS_LO] <= ps_r;
					hrdata_r[`GTC_TC_SYNC_DIS]            <= sync_dis_r;
					hrdata_r[`GTC_TC_ON]                  <= on_r;
				end
				`GTC_OFS_GCTRL: begin
					hrdata_r[`GTC_GC_GE]   <= ge_r;
					hrdata_r[`GTC_GC_POL]  <= pol_r;
					hrdata_r[`GTC_GC_TM]   <= tm_r;
					hrdata_r[`GTC_GC_GVAL] <= gate_lvl;
					hrdata_r[`GTC_GC_GSS]  <= gss_r;
				end
				`GTC_OFS_STATUS: hrdata_r[`GTC_ST_OVF] <= ovf_r;
				default: hrdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			cs_r       <= gtc_pkg::GTC_CS_INSTR;
			ps_r       <= gtc_pkg::GTC_PS_DIV1;
			sync_dis_r <= 1'b0;
			on_r       <= 1'b0;
		end else if (wr_tc) begin
			cs_r       <= gtc_pkg::gtc_clk_src_t'(hwdata_i[`GTC_TC_CS_HI:`GTC_TC_CS_LO]);
			ps_r       <= gtc_pkg::gtc_prescale_t'(hwdata_i[`GTC_TC_PS_HI:`GTC_TC_PS_LO]);
			sync_dis_r <= hwdata_i[`GTC_TC_SYNC_DIS];
			on_r       <= hwdata_i[`GTC_TC_ON];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			ge_r  <= 1'b0;
			pol_r <= 1'b0;
			tm_r  <= 1'b0;
			gss_r <= 1'b0;
		end else if (wr_gc) begin
			ge_r  <= hwdata_i[`GTC_GC_GE];
			pol_r <= hwdata_i[`GTC_GC_POL];
			tm_r  <= hwdata_i[`GTC_GC_TM];
			gss_r <= hwdata_i[`GTC_GC_GSS];
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			pin_s_r    <= 3'h0;
			gpin_s_r   <= 3'h0;
			lfo_s_r    <= 3'h0;
			pin_lvl_r  <= 1'b0;
			pin_dly_r  <= 1'b0;
			gpin_lvl_r <= 1'b0;
			lfo_lvl_r  <= 1'b0;
			lfo_dly_r  <= 1'b0;
			pin_prev_r <= 1'b0;
		end else begin
			pin_s_r    <= {pin_s_r[1:0], external_count_clock_pin_i};
			gpin_s_r   <= {gpin_s_r[1:0], gate_pin_i};
			lfo_s_r    <= {lfo_s_r[1:0], low_freq_internal_osc_i};
			pin_lvl_r  <= sync_lvl(pin_s_r, pin_lvl_r);
			gpin_lvl_r <= sync_lvl(gpin_s_r, gpin_lvl_r);
			lfo_lvl_r  <= sync_lvl(lfo_s_r, lfo_lvl_r);
			pin_dly_r  <= pin_lvl_r;
			lfo_dly_r  <= lfo_lvl_r;
			pin_prev_r <= pin_use;
		end
	end

	// Synchronous mode adds one phase-aligning stage; async skips it
	assign pin_use = sync_dis_r ? pin_lvl_r : pin_dly_r;

	// Falling edge must be seen before the first counting rising edge
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			arm_r <= 1'b0;
		end else if (!on_r || wr_cnt) begin
			arm_r <= 1'b0;
		end else if (pin_prev_r && !pin_use) begin
			arm_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Gate path
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			comp_prev_r <= `GTC_RST_BYTE;
			gsrc_prev_r <= 1'b0;
		end else begin
			comp_prev_r <= companion_count_i;
			gsrc_prev_r <= gsrc;
		end
	end

	assign wrap_pulse = (comp_prev_r == `GTC_WRAP_FROM)
		&& (companion_count_i == `GTC_WRAP_TO);
	assign gsrc = gss_r ? wrap_pulse : gpin_lvl_r;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			tff_r <= 1'b0;
		end else if (!tm_r || !on_r) begin
			tff_r <= 1'b0;
		end else if (gsrc && !gsrc_prev_r) begin
			tff_r <= ~tff_r;
		end
	end

	assign gate_lvl = tm_r ? tff_r : gsrc;
	assign gate_ok  = (gate_lvl == pol_r);

	// ----------------------------------------
	// Count clock and prescaler
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			instr_div_r <= 2'h0;
		end else begin
			instr_div_r <= instr_div_r + `GTC_INSTR_ONE;
		end
	end

	always_comb begin
		case (cs_r)
			gtc_pkg::GTC_CS_INSTR: src_tick = (instr_div_r == `GTC_INSTR_LAST);
			gtc_pkg::GTC_CS_SYS:   src_tick = 1'b1;
			gtc_pkg::GTC_CS_PIN:   src_tick = arm_r && pin_use && !pin_prev_r;
			gtc_pkg::GTC_CS_LFOSC: src_tick = lfo_lvl_r && !lfo_dly_r;
			default:               src_tick = 1'b0;
		endcase
	end

	// Sleep freezes all but the asynchronous pin counter
	assign run_ok   = !sleep_i || (sync_dis_r && (cs_r == gtc_pkg::GTC_CS_PIN));
	assign count_en = on_r && (!ge_r || gate_ok) && run_ok;
	assign pre_tick = src_tick && ((pre_r & pre_mask(ps_r)) == pre_mask(ps_r));
	assign inc      = count_en && pre_tick;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			pre_r <= `GTC_PRE_ZERO;
		end else if (wr_cnt) begin
			pre_r <= `GTC_PRE_ZERO;
		end else if (count_en && src_tick) begin
			pre_r <= pre_tick ? `GTC_PRE_ZERO : pre_r + `GTC_PRE_ONE;
		end
	end

	// ----------------------------------------
	// Counter and overflow
	// ----------------------------------------
	always_comb begin
		count_nxt = inc ? count_r + `GTC_CNT_ONE : count_r;
		if (wr_lo) begin
			count_nxt[7:0] = hwdata_i[7:0];
		end
		if (wr_hi) begin
			count_nxt[15:8] = hwdata_i[7:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			count_r <= `GTC_RST_CNT;
		end else begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			ovf_r <= 1'b0;
		end else if (inc && (count_r == `GTC_CNT_MAX)) begin
			ovf_r <= 1'b1;
		end else if (wr_st && hwdata_i[`GTC_ST_OVF]) begin
			ovf_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			wake_r <= 1'b0;
		end else begin
			wake_r <= ovf_r && sleep_i;
		end
	end

	assign overflow_flag_o = ovf_r;
	assign wake_o          = wake_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_off_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!on_r && !wr_cnt) |=> $stable(count_r))
		else $error("count moved while off");
	a_low_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_lo |=> (count_r[7:0] == $past(hwdata_i[7:0])))
		else $error("low byte write lost");
	a_sys_rate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(on_r && !ge_r && !sleep_i && !wr_cnt && cs_r == gtc_pkg::GTC_CS_SYS
		&& ps_r == gtc_pkg::GTC_PS_DIV1) |=> (count_r == $past(count_r) + `GTC_CNT_ONE))
		else $error("system clock count missed");
	a_gate_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(on_r && ge_r && (gate_lvl != pol_r) && !wr_cnt) |=> $stable(count_r))
		else $error("count moved with gate closed");
	a_ovf_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(inc && count_r == `GTC_CNT_MAX && !wr_cnt) |=> (ovf_r && count_r == `GTC_RST_CNT))
		else $error("rollover did not flag");
	a_ovf_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(ovf_r && !wr_st) |=> ovf_r)
		else $error("overflow flag dropped");
	a_tff_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!tm_r |=> !tff_r)
		else $error("toggle flop not held clear");
	a_pre_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_cnt |=> (pre_r == `GTC_PRE_ZERO))
		else $error("prescaler not cleared");
	a_pin_armed: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!on_r || wr_cnt) |=> !arm_r)
		else $error("pin count before falling edge");
	a_div2_rate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(inc && ps_r == gtc_pkg::GTC_PS_DIV2 && cs_r == gtc_pkg::GTC_CS_SYS) |=> !inc)
		else $error("divide by two ran too fast");
	a_wrap_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(gss_r && !tm_r && $past(companion_count_i) == `GTC_WRAP_FROM
		&& companion_count_i == `GTC_WRAP_TO) |-> gate_lvl)
		else $error("wrap pulse missing on gate");

endmodule

`default_nettype wire

// ==== sim/gtc_src_model.sv ====
// Purpose: Far-side pin and companion sources
// Assumes: Called from bench tasks
// Notes:   Levels change just after clk edges
`default_nettype none

module gtc_src_model (
	input  wire logic       clk_i,
	output logic            ext_clk_o,
	output logic            gate_o,
	output logic            osc_o,
	output logic [7:0]      comp_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Slow oscillator, period of 8 clocks
	// ----------------------------------------
	logic [2:0] osc_div_r = 3'h0;

	always_ff @(posedge clk_i) begin
		osc_div_r <= osc_div_r + 3'h1;
	end
	assign osc_o = osc_div_r[2];

	initial begin
		ext_clk_o = 1'b0;
		gate_o = 1'b0;
		comp_o = 8'h00;
	end

	// ----------------------------------------
	// Pin and companion stimulus
	// ----------------------------------------
	task automatic pin_set(input logic v);
		@(posedge clk_i);
		ext_clk_o <= v;
		repeat (8) @(posedge clk_i);
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			pin_set(1'b0);
			pin_set(1'b1);
		end
	endtask

	task automatic gate_set(input logic v);
		@(posedge clk_i);
		gate_o <= v;
		repeat (8) @(posedge clk_i);
	endtask

	// One companion wrap FF to 00
	task automatic wrap();
		@(posedge clk_i);
		comp_o <= 8'hFF;
		@(posedge clk_i);
		comp_o <= 8'h00;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

`default_nettype wire

// ==== sim/gated_16bit_timer_counter_tb.sv ====
// Purpose: Self-checking bench for the gated timer
// Assumes: Zero wait state AHB-Lite slave
// Notes:   Rates checked as count deltas
`include "gtc_params.svh"
`default_nettype none

module gated_16bit_timer_counter_tb;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [7:0] tc;
		logic [7:0] gc;
		logic       g;
		logic [7:0] ex;
	} gtc_row_t;

	localparam logic [31:0] a_lo = {24'h0, `GTC_OFS_CNT_LO};
	localparam logic [31:0] a_hi = {24'h0, `GTC_OFS_CNT_HI};
	localparam logic [31:0] a_tc = {24'h0, `GTC_OFS_TCTRL};
	localparam logic [31:0] a_gc = {24'h0, `GTC_OFS_GCTRL};
	localparam logic [31:0] a_st = {24'h0, `GTC_OFS_STATUS};
	localparam gtc_row_t rows [14] = '{
		'{8'h41, 8'h00, 1'b0, 8'h40}, '{8'h51, 8'h00, 1'b0, 8'h20},
		'{8'h61, 8'h00, 1'b0, 8'h10}, '{8'h71, 8'h00, 1'b0, 8'h08},
		'{8'h01, 8'h00, 1'b0, 8'h10}, '{8'h11, 8'h00, 1'b0, 8'h08},
		'{8'h21, 8'h00, 1'b0, 8'h04}, '{8'h31, 8'h00, 1'b0, 8'h02},
		'{8'hC1, 8'h00, 1'b0, 8'h08}, '{8'h40, 8'hC0, 1'b1, 8'h00},
		'{8'h41, 8'hC0, 1'b0, 8'h00}, '{8'h41, 8'hC0, 1'b1, 8'h40},
		'{8'h41, 8'h80, 1'b0, 8'h40}, '{8'h41, 8'h80, 1'b1, 8'h00}
	};

	logic        clk_sys_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic        sleep = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        ext_clk;
	logic        gate;
	logic        osc;
	logic [7:0]  comp;
	logic        ovf;
	logic        wake;
	logic [31:0] v0;
	logic [31:0] v1;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cycles = 0;

	gtc_timer u_dut (
		.clk_sys_i                  (clk_sys_i),
		.rst_b_i                    (rst_b_i),
		.hsel_i                     (hsel),
		.haddr_i                    (haddr),
		.htrans_i                   (htrans),
		.hwrite_i                   (hwrite),
		.hsize_i                    (hsize),
		.hwdata_i                   (hwdata),
		.hready_i                   (hreadyout),
		.hrdata_o                   (hrdata),
		.hreadyout_o                (hreadyout),
		.hresp_o                    (hresp),
		.external_count_clock_pin_i (ext_clk),
		.gate_pin_i                 (gate),
		.low_freq_internal_osc_i    (osc),
		.companion_count_i          (comp),
		.sleep_i                    (sleep),
		.overflow_flag_o            (ovf),
		.wake_o                     (wake)
	);

	gtc_src_model u_src (
		.clk_i     (clk_sys_i),
		.ext_clk_o (ext_clk),
		.gate_o    (gate),
		.osc_o     (osc),
		.comp_o    (comp)
	);

	always #5 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge clk_sys_i);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, d, r);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		xfer(a, 1'b0, 32'h0, d);
	endtask

	// Low byte advance over 64 clocks
	task automatic meas(input string nm, input logic [7:0] exp);
		logic [31:0] p;
		logic [31:0] q;
		rd(a_lo, p);
		repeat (61) @(posedge clk_sys_i);
		rd(a_lo, q);
		chk(nm, {24'h0, q[7:0] - p[7:0]}, {24'h0, exp});
	endtask

	task automatic end_of_test();
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			rd(a_lo + 32'(4 * k), v0);
			chk("reset reg", v0 & ~((k == 3) ? 32'h4 : 32'h0), 32'h0);
		end
		chk("reset ovf", {31'h0, ovf}, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		chk("hreadyout", {31'h0, hreadyout}, 32'h1);
		for (int i = 0; i < 14; i++) begin
			u_src.gate_set(rows[i].g);
			wr(a_tc, 32'h0);
			wr(a_lo, 32'h0);
			wr(a_gc, {24'h0, rows[i].gc});
			wr(a_tc, {24'h0, rows[i].tc});
			repeat (8) @(posedge clk_sys_i);
			meas("row", rows[i].ex);
		end
		wr(a_tc, 32'h0);
		wr(a_lo, 32'h34);
		wr(a_hi, 32'h12);
		wr(a_lo, 32'h56);
		rd(a_hi, v0);
		chk("hi byte", v0, 32'h12);
		rd(a_lo, v0);
		chk("lo byte", v0, 32'h56);
		wr(a_gc, 32'h0);
		wr(a_lo, 32'hFF);
		wr(a_hi, 32'hFF);
		wr(a_tc, 32'h41);
		repeat (10) @(posedge clk_sys_i);
		wr(a_tc, 32'h0);
		chk("ovf set", {31'h0, ovf}, 32'h1);
		rd(a_hi, v0);
		chk("wrap hi", v0, 32'h0);
		wr(a_st, 32'h1);
		rd(a_st, v0);
		chk("ovf clr", v0, 32'h0);
		u_src.pin_set(1'b0);
		wr(a_lo, 32'h0);
		wr(a_tc, 32'h81);
		u_src.pin_set(1'b1);
		rd(a_lo, v0);
		chk("first rise", v0, 32'h0);
		u_src.pulses(3);
		rd(a_lo, v0);
		chk("pin count", v0, 32'h3);
		wr(a_tc, 32'h0);
		wr(a_lo, 32'hFD);
		wr(a_hi, 32'hFF);
		wr(a_tc, 32'h85);
		sleep <= 1'b1;
		u_src.pulses(3);
		chk("sleep ovf", {31'h0, ovf}, 32'h1);
		chk("wake", {31'h0, wake}, 32'h1);
		sleep <= 1'b0;
		wr(a_tc, 32'h0);
		wr(a_st, 32'h1);
		u_src.gate_set(1'b1);
		wr(a_lo, 32'h0);
		wr(a_gc, 32'hC1);
		wr(a_tc, 32'h41);
		rd(a_lo, v0);
		u_src.wrap();
		rd(a_lo, v1);
		chk("wrap pulse", v1 - v0, 32'h1);
		wr(a_gc, 32'hE1);
		meas("tgl idle", 8'h00);
		u_src.wrap();
		meas("tgl on", 8'h40);
		u_src.wrap();
		meas("tgl off", 8'h00);
		u_src.wrap();
		wr(a_gc, 32'hC1);
		wr(a_gc, 32'hE1);
		meas("tgl clr", 8'h00);
		u_src.wrap();
		wr(a_tc, 32'h40);
		wr(a_tc, 32'h41);
		meas("on clr", 8'h00);
		wr(a_tc, 32'h0);
		wr(a_gc, 32'h0);
		wr(a_lo, 32'hFE);
		wr(a_hi, 32'hFF);
		wr(a_tc, 32'h41);
		repeat (4) @(posedge clk_sys_i);
		chk("pre rst ovf", {31'h0, ovf}, 32'h1);
		rst_b_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		chk("rst ovf", {31'h0, ovf}, 32'h0);
		rd(a_tc, v0);
		chk("rst tctrl", v0, 32'h0);
		rd(a_lo, v0);
		chk("rst lo", v0, 32'h0);
		rd(a_hi, v0);
		chk("rst hi", v0, 32'h0);
		end_of_test();
	end
endmodule

`default_nettype wire
